// [shared/ext_mem_consts.svh]
/*
 constants of the external memory, boot and bus hand-off block.
 assumes it is included by the main design module.
*/
`ifndef EXT_MEM_CONSTS_SVH
`define EXT_MEM_CONSTS_SVH

`define PM_WAIT_RST      3'h7
`define DM_WAIT_RST      3'h7
`define BOOT_WAIT_RST    3'h3
`define PM_INT_LO_BASE   14'h0000
`define PM_INT_LO_END    14'h01ff
`define PM_EXT_LO_BASE   14'h0800
`define PM_INT_HI_BASE   14'h3800
`define PM_INT_HI_END    14'h39ff
`define DM_INT_BASE      14'h3800
`define DM_RSV_BASE      14'h3900
`define DM_ZONE1_BASE    14'h0800
`define DM_ZONE2_BASE    14'h1000
`define DM_ZONE3_BASE    14'h1800
`define DM_ZONE4_BASE    14'h2000
`define BOOT_LAST_BYTE   2'h2
`define REG_CTRL         8'h00
`define REG_WAIT         8'h04
`define REG_DM_WAIT      8'h08
`define REG_STATUS       8'h0c
`define REG_PX           8'h10
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2

`endif

// [shared/ext_mem_pkg.sv]
/*
 types shared by the external memory block and its users.
 assumes the core side holds a request steady until it is answered.
*/
`default_nettype none
package ext_mem_pkg;

   typedef struct packed {
      logic        valid;
      logic        prog;
      logic        word16;
      logic        we;
      logic [13:0] addr;
      logic [23:0] wdata;
   } core_req_s;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CORE_EXT,
      ST_BOOT_BYTE
   } bus_state_e;

endpackage
`default_nettype wire

// [design/wait_counter.sv]
/*
 down counter that times the strobe length of one external access.
 assumes load is only raised while the counter is idle.
*/
`timescale 1ns/10ps
`default_nettype none
module wait_counter #(
   parameter int WIDTH = 3
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] waits,
   output logic                  busy,
   output logic                  last
);
   logic [WIDTH-1:0] count_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_reg <= '0;
         busy      <= 1'b0;
      end
      else if (load)
      begin
         count_reg <= waits;
         busy      <= 1'b1;
      end
      else if (busy)
      begin
         if (count_reg == '0)
            busy <= 1'b0;
         else
            count_reg <= count_reg - 1'b1;
      end
   end

   assign last = busy && (count_reg == '0);
endmodule
`default_nettype wire

// [design/ext_memory_boot_bus_interface.sv]
/*
 external memory interface: shared address/data pins, program/data/boot
 selects, wait states, boot loader and bus hand-off, AXI4-Lite registers.
 assumes the memories answer on aclk; bus request and map pin are async.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ext_mem_consts.svh"
module ext_memory_boot_bus_interface #(
   parameter int BOOT_WORDS = 512
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire ext_mem_pkg::core_req_s core_req,
   output logic                       core_ready,
   output logic [23:0]                core_rdata,
   output logic                       core_halt,
   output logic                       booting,
   output logic [13:0]                addr_out,
   output logic                       addr_oe,
   input  wire logic [23:0]           data_in,
   output logic [23:0]                data_out,
   output logic [23:0]                data_oe,
   output logic                       prog_mem_select_n,
   output logic                       data_mem_select_n,
   output logic                       boot_mem_select_n,
   output logic                       rd_n,
   output logic                       wr_n,
   output logic                       strobe_oe,
   input  wire logic                  bus_request_n,
   output logic                       bus_grant_n,
   input  wire logic                  map_select_pin
);
   ext_mem_pkg::bus_state_e state_reg;
   logic [1:0]  br_sync_reg;
   logic [1:0]  map_sync_reg;
   logic        br_active;
   logic        grant_reg;
   logic [2:0]  pm_wait_reg;
   logic [2:0]  boot_wait_reg;
   logic [14:0] dm_wait_reg;
   logic [2:0]  boot_page_reg;
   logic        go_mode_reg;
   logic        force_boot;
   logic        boot_req_reg;
   logic [7:0]  prog_extension_reg;
   logic [23:0] prog_ram [0:511];
   logic [15:0] data_ram [0:255];
   logic [1:0]  boot_byte_reg;
   logic [10:0] boot_addr_reg;
   logic [8:0]  boot_word_reg;
   logic [23:0] boot_buf_reg;
   logic        cur_prog_reg;
   logic        cur_word16_reg;
   logic        cur_we_reg;
   logic        ext_needed;
   logic        can_access;
   logic        start_ext;
   logic        start_int;
   logic        start_boot;
   logic [2:0]  launch_waits;
   logic        wc_load;
   logic        wc_last;
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic        wr_go;
   logic [3:0]  w_strb_reg;
   logic        boot_check_reg;

   function automatic logic int_prog(input logic [13:0] a, input logic map_hi);
      if (map_hi)
         int_prog = (a >= `PM_INT_HI_BASE) && (a <= `PM_INT_HI_END);
      else
         int_prog = (a < `PM_EXT_LO_BASE);
   endfunction

   function automatic logic [2:0] zone_of(input logic [13:0] a);
      if (a < `DM_ZONE1_BASE)
         zone_of = 3'h0;
      else if (a < `DM_ZONE2_BASE)
         zone_of = 3'h1;
      else if (a < `DM_ZONE3_BASE)
         zone_of = 3'h2;
      else if (a < `DM_ZONE4_BASE)
         zone_of = 3'h3;
      else
         zone_of = 3'h4;
   endfunction

   // bus request and map pin are asynchronous to aclk; not reset so a
   // request is seen even while reset is held
   always_ff @(posedge aclk)
   begin
      br_sync_reg  <= {br_sync_reg[0], ~bus_request_n};
      map_sync_reg <= {map_sync_reg[0], map_select_pin};
   end
   assign br_active = br_sync_reg[1];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         grant_reg <= br_active;
      else if (br_active && state_reg == ext_mem_pkg::ST_IDLE)
         grant_reg <= 1'b1;
      else if (!br_active)
         grant_reg <= 1'b0;
   end

   assign bus_grant_n = ~grant_reg;
   assign addr_oe     = ~grant_reg;
   assign strobe_oe   = ~grant_reg;
   assign booting     = boot_req_reg;

   // memory space and address, and for program the map pin, decide whether the pins are needed
   assign ext_needed = core_req.prog ? !int_prog(core_req.addr, map_sync_reg[1])
                                     : (core_req.addr < `DM_INT_BASE);
   assign core_halt  = boot_req_reg || (grant_reg && (!go_mode_reg
                                        || (core_req.valid && ext_needed)));
   assign can_access = core_req.valid && !core_halt && !core_ready
                       && state_reg == ext_mem_pkg::ST_IDLE;
   assign start_ext  = can_access && ext_needed && !br_active && !grant_reg;
   assign start_int  = can_access && !ext_needed;
   assign start_boot = boot_req_reg && !map_sync_reg[1] && !br_active && !grant_reg
                       && state_reg == ext_mem_pkg::ST_IDLE;
   assign wc_load    = start_ext || start_boot;

   always_comb
   begin
      launch_waits = pm_wait_reg;
      if (start_boot)
         launch_waits = boot_wait_reg;
      else if (!core_req.prog)
         launch_waits = dm_wait_reg[3*zone_of(core_req.addr) +: 3];
   end

   wait_counter #(
      .WIDTH (3)
   ) u_wait (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (wc_load),
      .waits   (launch_waits),
      .busy    (),
      .last    (wc_last)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= ext_mem_pkg::ST_IDLE;
      else
      begin
         case (state_reg)
            ext_mem_pkg::ST_IDLE:
               if (start_boot)
                  state_reg <= ext_mem_pkg::ST_BOOT_BYTE;
               else if (start_ext)
                  state_reg <= ext_mem_pkg::ST_CORE_EXT;
            ext_mem_pkg::ST_CORE_EXT,
            ext_mem_pkg::ST_BOOT_BYTE:
               if (wc_last)
                  state_reg <= ext_mem_pkg::ST_IDLE;
            default:
               state_reg <= ext_mem_pkg::ST_IDLE;
         endcase
      end
   end

   // pins change at the same edge as the state, so strobes span the access
   always_ff @(posedge aclk)
   begin
      if (!aresetn || wc_last)
      begin
         prog_mem_select_n <= 1'b1;
         data_mem_select_n <= 1'b1;
         boot_mem_select_n <= 1'b1;
         rd_n              <= 1'b1;
         wr_n              <= 1'b1;
         data_oe           <= '0;
      end
      else if (start_boot)
      begin
         boot_mem_select_n <= 1'b0;
         rd_n              <= 1'b0;
         addr_out          <= {boot_page_reg[0], 2'h0, boot_addr_reg};
         data_out          <= {boot_page_reg[2:1], 22'h0};
         data_oe           <= {2'h3, 22'h0};
      end
      else if (start_ext)
      begin
         prog_mem_select_n <= ~core_req.prog;
         data_mem_select_n <= core_req.prog;
         rd_n              <= core_req.we;
         wr_n              <= ~core_req.we;
         addr_out          <= core_req.addr;
         if (!core_req.prog)
            data_out <= {core_req.wdata[15:0], 8'h00};
         else if (core_req.word16)
            data_out <= {core_req.wdata[15:0], prog_extension_reg};
         else
            data_out <= core_req.wdata;
         data_oe <= core_req.we ? (core_req.prog ? 24'hffffff : 24'hffff00) : 24'h0;
      end
      if (!aresetn)
      begin
         addr_out <= '0;
         data_out <= '0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (start_ext)
      begin
         cur_prog_reg   <= core_req.prog;
         cur_word16_reg <= core_req.word16;
         cur_we_reg     <= core_req.we;
      end
   end

   // core answers: one-cycle ready pulse, data from flip-flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_ready <= 1'b0;
         core_rdata <= '0;
      end
      else
      begin
         core_ready <= start_int || (state_reg == ext_mem_pkg::ST_CORE_EXT && wc_last);
         if (state_reg == ext_mem_pkg::ST_CORE_EXT && wc_last && !cur_we_reg)
         begin
            if (!cur_prog_reg)
               core_rdata <= {8'h00, data_in[23:8]};
            else if (cur_word16_reg)
               core_rdata <= {8'h00, data_in[23:8]};
            else
               core_rdata <= data_in;
         end
         else if (start_int && !core_req.we)
         begin
            if (core_req.prog && core_req.addr[13:9] == int_prog_bank(core_req.addr))
               core_rdata <= core_req.word16 ? {8'h00, prog_ram[core_req.addr[8:0]][23:8]}
                                             : prog_ram[core_req.addr[8:0]];
            else if (!core_req.prog && core_req.addr < `DM_RSV_BASE)
               core_rdata <= {8'h00, data_ram[core_req.addr[7:0]]};
            else
               core_rdata <= '0;
         end
      end
   end

   function automatic logic [4:0] int_prog_bank(input logic [13:0] a);
      logic [13:0] base;
      base = map_sync_reg[1] ? `PM_INT_HI_BASE : `PM_INT_LO_BASE;
      int_prog_bank = base[13:9];
   endfunction

   always_ff @(posedge aclk)
   begin
      if (start_int && core_req.we && core_req.prog
          && core_req.addr[13:9] == int_prog_bank(core_req.addr))
         prog_ram[core_req.addr[8:0]] <= core_req.word16
                  ? {core_req.wdata[15:0], prog_extension_reg} : core_req.wdata;
      else if (state_reg == ext_mem_pkg::ST_BOOT_BYTE && wc_last
               && boot_byte_reg == `BOOT_LAST_BYTE)
         prog_ram[boot_word_reg] <= {boot_buf_reg[15:0], data_in[15:8]};
      if (start_int && core_req.we && !core_req.prog && core_req.addr < `DM_RSV_BASE)
         data_ram[core_req.addr[7:0]] <= core_req.wdata[15:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prog_extension_reg <= '0;
      else if (wr_go && aw_addr_reg == `REG_PX)
         prog_extension_reg <= w_data_reg[7:0];
      else if (state_reg == ext_mem_pkg::ST_CORE_EXT && wc_last && cur_prog_reg
               && cur_word16_reg && !cur_we_reg)
         prog_extension_reg <= data_in[7:0];
      else if (start_int && core_req.prog && core_req.word16 && !core_req.we)
         prog_extension_reg <= prog_ram[core_req.addr[8:0]][7:0];
   end

   // only the first edge after reset release may cancel the automatic boot,
   // so a request during a forced boot merely pauses it
   always_ff @(posedge aclk)
   begin
      boot_check_reg <= !aresetn;
   end

   // boot sequencer: three bytes, high byte first, per program word
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         boot_req_reg  <= 1'b1;
         boot_byte_reg <= '0;
         boot_addr_reg <= '0;
         boot_word_reg <= '0;
         boot_buf_reg  <= '0;
      end
      else if (boot_check_reg && (map_sync_reg[1] || br_active))
         boot_req_reg <= 1'b0;
      else if (force_boot && !boot_req_reg && !map_sync_reg[1])
      begin
         boot_req_reg  <= 1'b1;
         boot_byte_reg <= '0;
         boot_addr_reg <= '0;
         boot_word_reg <= '0;
      end
      else if (state_reg == ext_mem_pkg::ST_BOOT_BYTE && wc_last)
      begin
         boot_buf_reg  <= {boot_buf_reg[15:0], data_in[15:8]};
         boot_addr_reg <= boot_addr_reg + 11'h1;
         if (boot_byte_reg == `BOOT_LAST_BYTE)
         begin
            boot_byte_reg <= '0;
            boot_word_reg <= boot_word_reg + 9'h1;
            if (boot_word_reg == 9'(BOOT_WORDS - 1))
               boot_req_reg <= 1'b0;
         end
         else
            boot_byte_reg <= boot_byte_reg + 2'h1;
      end
   end

   // AXI4-Lite slave: address and data taken in either order
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign wr_go         = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign force_boot    = wr_go && aw_addr_reg == `REG_CTRL && w_data_reg[3];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg <= `REG_PX && aw_addr_reg[1:0] == 2'h0
                             && aw_addr_reg != `REG_STATUS) ? `AXI_OKAY : `AXI_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pm_wait_reg   <= `PM_WAIT_RST;
         boot_wait_reg <= `BOOT_WAIT_RST;
         dm_wait_reg   <= {5{`DM_WAIT_RST}};
         boot_page_reg <= '0;
         go_mode_reg   <= 1'b0;
      end
      else if (wr_go && aw_addr_reg == `REG_CTRL && w_strb_reg[0])
      begin
         boot_page_reg <= w_data_reg[2:0];
         go_mode_reg   <= w_data_reg[4];
      end
      else if (wr_go && aw_addr_reg == `REG_WAIT && w_strb_reg[0])
      begin
         pm_wait_reg   <= w_data_reg[2:0];
         boot_wait_reg <= w_data_reg[5:3];
      end
      else if (wr_go && aw_addr_reg == `REG_DM_WAIT)
         dm_wait_reg <= w_data_reg[14:0];
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `AXI_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `AXI_OKAY;
         case (s_axi_araddr)
            `REG_CTRL:    s_axi_rdata <= {27'h0, go_mode_reg, 1'b0, boot_page_reg};
            `REG_WAIT:    s_axi_rdata <= {26'h0, boot_wait_reg, pm_wait_reg};
            `REG_DM_WAIT: s_axi_rdata <= {17'h0, dm_wait_reg};
            `REG_STATUS:  s_axi_rdata <= {28'h0, map_sync_reg[1], core_halt,
                                          boot_req_reg, grant_reg};
            `REG_PX:      s_axi_rdata <= {24'h0, prog_extension_reg};
            default:
            begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `AXI_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_grant_floats;
      grant_reg |-> !addr_oe && !strobe_oe && !bus_grant_n && data_oe == '0;
   endproperty
   a_grant_floats: assert property (p_grant_floats) else $error("pins driven");

   property p_grant_next;
      br_active && !grant_reg && state_reg == ext_mem_pkg::ST_IDLE |=> grant_reg;
   endproperty
   a_grant_next: assert property (p_grant_next) else $error("grant not given next cycle");

   property p_release;
      !br_active && grant_reg |=> !grant_reg && addr_oe;
   endproperty
   a_release: assert property (p_release) else $error("grant held after release");

   property p_access_bound;
      $fell(state_reg == ext_mem_pkg::ST_IDLE) |-> ##[1:8] state_reg == ext_mem_pkg::ST_IDLE;
   endproperty
   a_access_bound: assert property (p_access_bound) else $error("access too long");

   property p_prog_select;
      state_reg == ext_mem_pkg::ST_CORE_EXT && cur_prog_reg
         |-> !prog_mem_select_n && data_mem_select_n && (rd_n != wr_n);
   endproperty
   a_prog_select: assert property (p_prog_select) else $error("program select wrong");

   property p_boot_pins;
      state_reg == ext_mem_pkg::ST_BOOT_BYTE |-> !boot_mem_select_n && !rd_n
         && data_oe[23:22] == 2'h3 && data_out[23:22] == boot_page_reg[2:1]
         && addr_out[13] == boot_page_reg[0];
   endproperty
   a_boot_pins: assert property (p_boot_pins) else $error("boot pins wrong");

   property p_reserved_internal;
      !data_mem_select_n |-> addr_out < `DM_INT_BASE;
   endproperty
   a_reserved_internal: assert property (p_reserved_internal) else $error("data went out");

   property p_reset_waits;
      $rose(aresetn) |-> pm_wait_reg == `PM_WAIT_RST && boot_wait_reg == `BOOT_WAIT_RST
                         && dm_wait_reg == {5{`DM_WAIT_RST}};
   endproperty
   a_reset_waits: assert property (p_reset_waits) else $error("wait reset values wrong");
endmodule
`default_nettype wire

// [verification/mem_model.sv]
/*
 behavioural external program/data/boot memory on the shared pins.
 assumes reads answer within the strobe, synchronous to aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module mem_model (
   input  wire logic        aclk,
   input  wire logic [13:0] addr_out,
   input  wire logic        rd_n,
   input  wire logic        strobe_oe,
   output logic [23:0]      data_in
);
   logic [23:0] last_q = 24'h000000;
   logic [23:0] pat;
   logic        rd;
   assign rd = !rd_n && strobe_oe;
   assign pat = {~addr_out[7:0], addr_out[7:0] ^ 8'h3c, addr_out[7:0]};
   // released bus shows the inverse of the last word, so a late sample cannot pass
   assign data_in = rd ? pat : ~last_q;
   always_ff @(posedge aclk)
   begin
      if (rd) last_q <= pat;
   end
endmodule
`default_nettype wire

// [verification/tb.sv]
/*
 testbench: boot, register resets, external program/data access, bus hand-off.
 assumes mem_model answers reads; boot shortened to four words.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic aclk = 1'b0, aresetn = 1'b0, map_select_pin = 1'b0, bus_request_n = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   ext_mem_pkg::core_req_s core_req = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic core_ready, core_halt, booting, addr_oe, prog_mem_select_n, data_mem_select_n;
   logic boot_mem_select_n, rd_n, wr_n, strobe_oe, bus_grant_n;
   logic [23:0] core_rdata, data_in, data_out, data_oe, q, wcap;
   logic [13:0] addr_out;
   logic [2:0] bpage;
   int error_cnt, n_compared, cyc, dsel, psel, bsel, wcnt, rcnt, n;
   ext_memory_boot_bus_interface #(.BOOT_WORDS(4)) i_dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .core_req, .core_ready, .core_rdata, .core_halt,
      .booting, .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .prog_mem_select_n,
      .data_mem_select_n, .boot_mem_select_n, .rd_n, .wr_n, .strobe_oe,
      .bus_request_n, .bus_grant_n, .map_select_pin);
   mem_model i_mem (.aclk, .addr_out, .rd_n, .strobe_oe, .data_in);
   always #50 aclk = ~aclk;
   always @(negedge aclk)
   begin
      if (!data_mem_select_n) dsel++;
      if (!prog_mem_select_n) psel++;
      if (!boot_mem_select_n) bsel++;
      if (!boot_mem_select_n) bpage = {data_out[23:22], addr_out[13]};
      if (!wr_n) wcnt++;
      if (!wr_n) wcap = data_out;
      if (!rd_n) rcnt++;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] wd);
      logic ta, tw, tr, tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      do
      begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tr = s_axi_arvalid & s_axi_arready;
         tb = w ? s_axi_bvalid : s_axi_rvalid;
         r = w ? s_axi_bresp : s_axi_rresp;
         d = s_axi_rdata;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         if (tb) s_axi_rready <= 1'b0;
      end
      while (!tb);
   endtask
   // k packs valid, program space, 16-bit width and write
   task automatic cr(input logic [3:0] k, input logic [13:0] a, input logic [23:0] wd);
      dsel = 0;
      psel = 0;
      wcnt = 0;
      rcnt = 0;
      @(posedge aclk);
      core_req <= {k, a, wd};
      do @(negedge aclk); while (!core_ready);
      q = core_rdata;
      @(posedge aclk);
      core_req <= '0;
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_boot;
      do @(negedge aclk); while (booting);
      chk("boot_sel", bsel > 0, 1);
      chk("boot_page", bpage, 0);
      cr(4'hc, 14'h0000, 24'h0);
      chk("boot_word", q, 24'h3c3d3e);
      $display("test boot done");
   endtask
   task automatic t_regs;
      ax(1'b0, 8'h04, 0);
      chk("waits", d, 32'h1f);
      ax(1'b0, 8'h08, 0);
      chk("dm_waits", d, 32'h7fff);
      ax(1'b0, 8'h20, 0);
      chk("unmapped", r, 2'h2);
      $display("test regs done");
   endtask
   task automatic t_data;
      cr(4'hb, 14'h1000, 24'h00a5c3);
      chk("dm_sel", dsel > 0 && psel == 0, 1);
      chk("dm_data", wcap[23:8], 16'ha5c3);
      chk("dm_wait", wcnt, 8);
      $display("test data done");
   endtask
   task automatic t_prog;
      ax(1'b1, 8'h04, 32'h18);
      chk("wait_resp", r, 0);
      cr(4'he, 14'h0805, 24'h0);
      chk("pm_rd", {psel > 0, q[15:0]}, 17'h1fa39);
      chk("pm_wait", rcnt, 1);
      cr(4'hf, 14'h0900, 24'h001234);
      chk("pm_wr", wcap, 24'h123405);
      cr(4'ha, 14'h3900, 24'h0);
      chk("rsv", dsel + rcnt, 0);
      chk("rsv_data", q, 0);
      $display("test prog done");
   endtask
   task automatic t_force_boot;
      bsel = 0;
      ax(1'b1, 8'h00, 32'hd);
      chk("ctrl_resp", r, 0);
      repeat (7) @(posedge aclk);
      bus_request_n <= 1'b0;
      do @(negedge aclk); while (bus_grant_n);
      chk("boot_grant", {booting, boot_mem_select_n}, 2'h3);
      @(posedge aclk);
      bus_request_n <= 1'b1;
      do @(negedge aclk); while (booting);
      chk("force_sel", bsel > 0, 1);
      chk("force_page", bpage, 5);
      $display("test force boot done");
   endtask
   task automatic t_map;
      @(posedge aclk);
      map_select_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      cr(4'hc, 14'h0100, 24'h0);
      chk("map_ext", {psel > 0, q}, 25'h1ff3c00);
      cr(4'hc, 14'h3800, 24'h0);
      chk("map_int", {psel > 0, q}, 25'h03c3d3e);
      map_select_pin <= 1'b0;
      $display("test map done");
   endtask
   task automatic t_bus;
      n = 0;
      bus_request_n <= 1'b0;
      do @(negedge aclk) n++; while (bus_grant_n);
      chk("grant", {n <= 4, core_halt, addr_oe, strobe_oe, data_oe}, 28'hc000000);
      @(posedge aclk);
      bus_request_n <= 1'b1;
      do @(negedge aclk); while (!bus_grant_n);
      chk("redrive", {addr_oe, strobe_oe}, 2'h3);
      ax(1'b1, 8'h00, 32'h10);
      bus_request_n <= 1'b0;
      do @(negedge aclk); while (bus_grant_n);
      chk("go_mode", core_halt, 0);
      @(posedge aclk);
      bus_request_n <= 1'b1;
      do @(negedge aclk); while (!bus_grant_n);
      $display("test bus done");
   endtask
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_boot();
      t_regs();
      t_data();
      t_prog();
      t_force_boot();
      t_map();
      t_bus();
      finish_test();
   end
endmodule
`default_nettype wire
